// ==== pif_pkg.sv ====
// constants, field layout and register map of the peripheral flag block
// assumes one system clock and a core that reaches the registers over a
// plain address/strobe port with read data one cycle after the strobe
//
// Function
// - converter done flag sets, software clears it
// - receive full flag clears on buffer read
// - transmit empty flag clears on buffer write
// - comparator flags set on output change
// - timer overflow flag sets, software clears it
// - first register bit 7 reads zero
// - oscillator fail flag sets, software clears it
// - write done flag sets, software clears it
// - flags set regardless of any enable
`default_nettype none

package pif_pkg;

  typedef logic [7:0] pif_byte_t;
  typedef logic [2:0] pif_addr_t;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam pif_addr_t OFF_FLAGS_ONE = 3'h0;
  localparam pif_addr_t OFF_FLAGS_TWO = 3'h1;
  localparam pif_addr_t OFF_ISTAT_ONE = 3'h2;
  localparam pif_addr_t OFF_ISTAT_TWO = 3'h3;
  localparam pif_addr_t OFF_IMASK_ONE = 3'h4;
  localparam pif_addr_t OFF_IMASK_TWO = 3'h5;

  ////////////////////////////////////////////////////////////////////////////
  // field positions, first flag register
  localparam int unsigned BIT_CONV_DONE = 6;
  localparam int unsigned BIT_RX_FULL   = 5;
  localparam int unsigned BIT_TX_EMPTY  = 4;
  localparam int unsigned BIT_CMP_BASE  = 1;
  localparam int unsigned NUM_CMP       = 3;
  localparam int unsigned BIT_TMR_OVF   = 0;

  // field positions, second flag register
  localparam int unsigned BIT_OSC_FAIL  = 7;
  localparam int unsigned BIT_NV_DONE   = 4;
  localparam int unsigned BIT_LOW_V     = 2;

  ////////////////////////////////////////////////////////////////////////////
  // implemented bits, reset values
  localparam pif_byte_t IMPL_ONE    = 8'h7f;
  localparam pif_byte_t IMPL_TWO    = 8'h94;
  localparam pif_byte_t RST_FLAGS   = 8'h00;
  localparam pif_byte_t RST_ISTAT   = 8'h00;
  localparam pif_byte_t RST_IMASK   = 8'h00;
  localparam pif_byte_t RST_RDATA   = 8'h00;
  localparam pif_byte_t UNMAPPED_RD = 8'h00;

endpackage : pif_pkg

`default_nettype wire

// ==== pif_evt_if.sv ====
// event carrier from the edge detector to the flag register file
// assumes both ends run on the same system clock
`default_nettype none

interface pif_evt_if;
  import pif_pkg::*;

  pif_byte_t set_one;
  pif_byte_t set_two;
  pif_byte_t clr_one;

  modport src (output set_one, output set_two, output clr_one);
  modport dst (input  set_one, input  set_two, input  clr_one);

endinterface : pif_evt_if

`default_nettype wire

// ==== pif_event_detect.sv ====
// turns the raw peripheral event lines into set and clear terms, one-cycle pulses except the low voltage level
// assumes every event input is synchronous to clock; pulse inputs are high
// for one cycle per event, level inputs may stay high for many cycles
`default_nettype none

module pif_event_detect
  import pif_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               rst_n,
  input  wire logic               conv_done,
  input  wire logic               rx_data_arrived,
  input  wire logic               rx_buffer_read,
  input  wire logic               tx_buffer_emptied,
  input  wire logic               tx_buffer_written,
  input  wire logic [NUM_CMP-1:0] comparator_out,
  input  wire logic               timer_overflow,
  input  wire logic               osc_failed,
  input  wire logic               nv_write_done,
  input  wire logic               low_voltage,
  pif_evt_if.src                  evt
);

  logic [NUM_CMP-1:0] cmp_prev_q;
  logic [NUM_CMP-1:0] cmp_chg;
  logic               osc_prev_q;
  logic               primed_q;

  ////////////////////////////////////////////////////////////////////////////
  // the first sample after reset only primes the history, so a comparator
  // that is already high at release does not fake a change
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      primed_q <= 1'b0;
    end else begin
      primed_q <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cmp_prev_q <= '0;
      osc_prev_q <= 1'b0;
    end else begin
      cmp_prev_q <= comparator_out;
      osc_prev_q <= osc_failed;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CMP; gi++) begin : g_cmp
      assign cmp_chg[gi] = primed_q & (comparator_out[gi] ^ cmp_prev_q[gi]);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    evt.set_one = '0;
    evt.set_one[BIT_CONV_DONE] = conv_done;
    evt.set_one[BIT_RX_FULL]   = rx_data_arrived;
    evt.set_one[BIT_TX_EMPTY]  = tx_buffer_emptied;
    evt.set_one[BIT_CMP_BASE +: NUM_CMP] = cmp_chg;
    evt.set_one[BIT_TMR_OVF]   = timer_overflow;
  end

  always_comb begin
    evt.set_two = '0;
    evt.set_two[BIT_OSC_FAIL] = osc_failed & ~osc_prev_q;
    evt.set_two[BIT_NV_DONE]  = nv_write_done;
    evt.set_two[BIT_LOW_V]    = low_voltage;
  end

  always_comb begin
    evt.clr_one = '0;
    evt.clr_one[BIT_RX_FULL]  = rx_buffer_read;
    evt.clr_one[BIT_TX_EMPTY] = tx_buffer_written;
  end

endmodule : pif_event_detect

`default_nettype wire

// ==== pif_top.sv ====
// peripheral interrupt flag registers with sticky interrupt status and mask
// assumes a core that issues one-cycle read or write strobes, never both,
// and peripherals whose event lines are synchronous to clock
`default_nettype none

module pif_top
  import pif_pkg::*;
(
  input  wire logic                        clock,
  input  wire logic                        rst_n,
  input  wire pif_pkg::pif_addr_t          reg_addr,
  input  wire pif_pkg::pif_byte_t          reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output var  pif_pkg::pif_byte_t          reg_rdata,
  output var  logic                        irq,
  input  wire logic                        conv_done,
  input  wire logic                        rx_data_arrived,
  input  wire logic                        rx_buffer_read,
  input  wire logic                        tx_buffer_emptied,
  input  wire logic                        tx_buffer_written,
  input  wire logic [pif_pkg::NUM_CMP-1:0] comparator_out,
  input  wire logic                        timer_overflow,
  input  wire logic                        osc_failed,
  input  wire logic                        nv_write_done,
  input  wire logic                        low_voltage
);

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  function automatic logic pif_hit(input pif_addr_t addr,
                                   input pif_addr_t offset,
                                   input logic      strobe);
    pif_hit = strobe && (addr == offset);
  endfunction

  logic wr_flags_one;
  logic wr_flags_two;
  logic wr_istat_one;
  logic wr_istat_two;
  logic wr_imask_one;
  logic wr_imask_two;
  logic rd_flags_one;

  assign wr_flags_one = pif_hit(reg_addr, OFF_FLAGS_ONE, reg_wr);
  assign wr_flags_two = pif_hit(reg_addr, OFF_FLAGS_TWO, reg_wr);
  assign wr_istat_one = pif_hit(reg_addr, OFF_ISTAT_ONE, reg_wr);
  assign wr_istat_two = pif_hit(reg_addr, OFF_ISTAT_TWO, reg_wr);
  assign wr_imask_one = pif_hit(reg_addr, OFF_IMASK_ONE, reg_wr);
  assign wr_imask_two = pif_hit(reg_addr, OFF_IMASK_TWO, reg_wr);
  assign rd_flags_one = pif_hit(reg_addr, OFF_FLAGS_ONE, reg_rd);

  ////////////////////////////////////////////////////////////////////////////
  // event edges and pulses

  pif_evt_if evt ();

  pif_event_detect u_detect (
    .clock             (clock),
    .rst_n             (rst_n),
    .conv_done         (conv_done),
    .rx_data_arrived   (rx_data_arrived),
    .rx_buffer_read    (rx_buffer_read),
    .tx_buffer_emptied (tx_buffer_emptied),
    .tx_buffer_written (tx_buffer_written),
    .comparator_out    (comparator_out),
    .timer_overflow    (timer_overflow),
    .osc_failed        (osc_failed),
    .nv_write_done     (nv_write_done),
    .low_voltage       (low_voltage),
    .evt               (evt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // first flag register
  // every flag below tests its set term first, so an event in the cycle of a
  // clear survives; no enable gates a set term

  logic               conv_done_q;
  logic               rx_full_q;
  logic               tx_empty_q;
  logic [NUM_CMP-1:0] cmp_flag_q;
  logic               tmr_ovf_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      conv_done_q <= RST_FLAGS[BIT_CONV_DONE];
    end else if (evt.set_one[BIT_CONV_DONE]) begin
      conv_done_q <= 1'b1;
    end else if (wr_flags_one) begin
      conv_done_q <= reg_wdata[BIT_CONV_DONE];
    end
  end

  // receive flag ignores software writes; only the buffer read clears it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_full_q <= RST_FLAGS[BIT_RX_FULL];
    end else if (evt.set_one[BIT_RX_FULL]) begin
      rx_full_q <= 1'b1;
    end else if (evt.clr_one[BIT_RX_FULL]) begin
      rx_full_q <= 1'b0;
    end
  end

  // transmit flag ignores software writes; only the buffer write clears it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_empty_q <= RST_FLAGS[BIT_TX_EMPTY];
    end else if (evt.set_one[BIT_TX_EMPTY]) begin
      tx_empty_q <= 1'b1;
    end else if (evt.clr_one[BIT_TX_EMPTY]) begin
      tx_empty_q <= 1'b0;
    end
  end

  // a read of the first register marks the comparators as seen; a write of
  // zero clears them as well
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CMP; gi++) begin : g_cmp_flag
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          cmp_flag_q[gi] <= RST_FLAGS[BIT_CMP_BASE + gi];
        end else if (evt.set_one[BIT_CMP_BASE + gi]) begin
          cmp_flag_q[gi] <= 1'b1;
        end else if (rd_flags_one) begin
          cmp_flag_q[gi] <= 1'b0;
        end else if (wr_flags_one) begin
          cmp_flag_q[gi] <= reg_wdata[BIT_CMP_BASE + gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tmr_ovf_q <= RST_FLAGS[BIT_TMR_OVF];
    end else if (evt.set_one[BIT_TMR_OVF]) begin
      tmr_ovf_q <= 1'b1;
    end else if (wr_flags_one) begin
      tmr_ovf_q <= reg_wdata[BIT_TMR_OVF];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // second flag register

  logic osc_fail_q;
  logic nv_done_q;
  logic low_v_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      osc_fail_q <= RST_FLAGS[BIT_OSC_FAIL];
    end else if (evt.set_two[BIT_OSC_FAIL]) begin
      osc_fail_q <= 1'b1;
    end else if (wr_flags_two) begin
      osc_fail_q <= reg_wdata[BIT_OSC_FAIL];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      nv_done_q <= RST_FLAGS[BIT_NV_DONE];
    end else if (evt.set_two[BIT_NV_DONE]) begin
      nv_done_q <= 1'b1;
    end else if (wr_flags_two) begin
      nv_done_q <= reg_wdata[BIT_NV_DONE];
    end
  end

  // the detector level keeps setting the flag, so a clear only sticks once
  // the supply has recovered
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      low_v_q <= RST_FLAGS[BIT_LOW_V];
    end else if (evt.set_two[BIT_LOW_V]) begin
      low_v_q <= 1'b1;
    end else if (wr_flags_two) begin
      low_v_q <= reg_wdata[BIT_LOW_V];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assembled flag views; unimplemented bits are constant zero

  pif_byte_t flags_one;
  pif_byte_t flags_two;

  always_comb begin
    flags_one = '0;
    flags_one[BIT_CONV_DONE]             = conv_done_q;
    flags_one[BIT_RX_FULL]               = rx_full_q;
    flags_one[BIT_TX_EMPTY]              = tx_empty_q;
    flags_one[BIT_CMP_BASE +: NUM_CMP]   = cmp_flag_q;
    flags_one[BIT_TMR_OVF]               = tmr_ovf_q;
  end

  always_comb begin
    flags_two = '0;
    flags_two[BIT_OSC_FAIL] = osc_fail_q;
    flags_two[BIT_NV_DONE]  = nv_done_q;
    flags_two[BIT_LOW_V]    = low_v_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky interrupt status, write one to clear, set beats clear

  pif_byte_t istat_one_q;
  pif_byte_t istat_two_q;
  pif_byte_t istat_one_d;
  pif_byte_t istat_two_d;

  always_comb begin
    istat_one_d = istat_one_q;
    if (wr_istat_one) begin
      istat_one_d = istat_one_q & ~reg_wdata;
    end
    istat_one_d = (istat_one_d | evt.set_one) & IMPL_ONE;
  end

  always_comb begin
    istat_two_d = istat_two_q;
    if (wr_istat_two) begin
      istat_two_d = istat_two_q & ~reg_wdata;
    end
    istat_two_d = (istat_two_d | evt.set_two) & IMPL_TWO;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      istat_one_q <= RST_ISTAT;
      istat_two_q <= RST_ISTAT;
    end else begin
      istat_one_q <= istat_one_d;
      istat_two_q <= istat_two_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt mask, one bit per status bit

  pif_byte_t imask_one_q;
  pif_byte_t imask_two_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      imask_one_q <= RST_IMASK;
      imask_two_q <= RST_IMASK;
    end else begin
      if (wr_imask_one) begin
        imask_one_q <= reg_wdata & IMPL_ONE;
      end
      if (wr_imask_two) begin
        imask_two_q <= reg_wdata & IMPL_TWO;
      end
    end
  end

  // registered from next-state values so irq tracks status with no extra lag
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |((istat_one_d & imask_one_q) | (istat_two_d & imask_two_q));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port: data stands only in the cycle after the strobe

  pif_byte_t rd_mux;

  always_comb begin
    unique case (reg_addr)
      OFF_FLAGS_ONE: rd_mux = flags_one;
      OFF_FLAGS_TWO: rd_mux = flags_two;
      OFF_ISTAT_ONE: rd_mux = istat_one_q;
      OFF_ISTAT_TWO: rd_mux = istat_two_q;
      OFF_IMASK_ONE: rd_mux = imask_one_q;
      OFF_IMASK_TWO: rd_mux = imask_two_q;
      default:       rd_mux = UNMAPPED_RD;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= RST_RDATA;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= RST_RDATA;
    end
  end

endmodule : pif_top

`default_nettype wire

// ==== pif_periph_model.sv ====
// far-side model: peripheral event sources seen by the flag block
// assumes the bench issues one command per go pulse, synchronous to clock
`default_nettype none

module pif_periph_model
  import pif_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic [3:0] evt_code,
  input  wire logic       evt_go,
  output var  logic [7:0] pulse,
  output var  logic [7:0] level
);
  // codes 0..6 give a one-cycle event pulse, codes 8..12 toggle a level
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pulse <= 8'h00;
      level <= 8'h00;
    end else begin
      pulse <= (evt_go && !evt_code[3]) ? 8'h01 << evt_code[2:0] : 8'h00;
      if (evt_go && evt_code[3]) begin
        level[evt_code[2:0]] <= ~level[evt_code[2:0]];
      end
    end
  end
endmodule // pif_periph_model

`default_nettype wire

// ==== pif_top_assertions.sv ====
// checker on the flag block ports, bound into pif_top
// assumes one clock domain and reads one cycle after the strobe
`default_nettype none

module pif_checker
  import pif_pkg::*;
(
  input wire logic               clock,
  input wire logic               rst_n,
  input wire pif_addr_t          reg_addr,
  input wire pif_byte_t          reg_wdata,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire pif_byte_t          reg_rdata,
  input wire logic               irq,
  input wire logic               conv_done,
  input wire logic               rx_data_arrived,
  input wire logic               rx_buffer_read,
  input wire logic               tx_buffer_emptied,
  input wire logic               tx_buffer_written,
  input wire logic [NUM_CMP-1:0] comparator_out,
  input wire logic               timer_overflow,
  input wire logic               osc_failed,
  input wire logic               nv_write_done,
  input wire logic               low_voltage
);
  logic               rd0, rd1, cause, cmp_moved;
  logic [NUM_CMP-1:0] cmp_prev_q;
  assign rd0 = reg_rd && reg_addr == OFF_FLAGS_ONE;
  assign rd1 = reg_rd && reg_addr == OFF_FLAGS_TWO;
  // a mask write may raise irq as well as any event
  assign cause = conv_done | rx_data_arrived | tx_buffer_emptied |
                 timer_overflow | nv_write_done | osc_failed | low_voltage |
                 cmp_moved | (reg_wr && reg_addr[2]);
  assign cmp_moved = comparator_out != cmp_prev_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cmp_prev_q <= '0;
    end else begin
      cmp_prev_q <= comparator_out;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  property p_idle; !$past(reg_rd) |-> reg_rdata == RST_RDATA; endproperty
  a_idle: assert property (p_idle) else $error("rdata not zero");
  property p_bit7; $past(rd0) |-> !reg_rdata[7]; endproperty
  a_bit7: assert property (p_bit7) else $error("bit 7 set");
  property p_two; $past(rd1) |-> (reg_rdata & ~IMPL_TWO) == 8'h00;
  endproperty
  a_two: assert property (p_two) else $error("unused bit set");
  property p_conv; conv_done ##1 rd0 |=> reg_rdata[BIT_CONV_DONE];
  endproperty
  a_conv: assert property (p_conv) else $error("conv flag low");
  property p_rx;
    rx_buffer_read && !rx_data_arrived ##1 rd0 && !rx_data_arrived
      |=> !reg_rdata[BIT_RX_FULL];
  endproperty
  a_rx: assert property (p_rx) else $error("rx flag stuck");
  property p_tmr; timer_overflow ##1 rd0 |=> reg_rdata[BIT_TMR_OVF];
  endproperty
  a_tmr: assert property (p_tmr) else $error("timer flag low");
  property p_osc; $rose(osc_failed) ##1 rd1 |=> reg_rdata[BIT_OSC_FAIL];
  endproperty
  a_osc: assert property (p_osc) else $error("osc flag low");
  property p_lv; low_voltage ##1 rd1 |=> reg_rdata[BIT_LOW_V]; endproperty
  a_lv: assert property (p_lv) else $error("low voltage flag low");
  property p_irq; $rose(irq) |-> $past(cause) || $past(cause, 2);
  endproperty
  a_irq: assert property (p_irq) else $error("irq without cause");
  c_conv: cover property (conv_done ##1 rd0);
  c_irq:  cover property ($rose(irq));
  c_rx:   cover property (rx_buffer_read ##1 rd0);
endmodule // pif_checker

bind pif_top pif_checker pif_checker_i (
  .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
  .conv_done(conv_done), .rx_data_arrived(rx_data_arrived),
  .rx_buffer_read(rx_buffer_read), .tx_buffer_emptied(tx_buffer_emptied),
  .tx_buffer_written(tx_buffer_written), .comparator_out(comparator_out),
  .timer_overflow(timer_overflow), .osc_failed(osc_failed),
  .nv_write_done(nv_write_done), .low_voltage(low_voltage));

`default_nettype wire

// ==== tb_peripheral_interrupt_flags.sv ====
// self-checking bench for the peripheral flag block
// assumes the periph model drives every event line of pif_top
`default_nettype none

module tb_peripheral_interrupt_flags import pif_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [3:0] C_CONV = 4'h0, C_RXA = 4'h1, C_RXR = 4'h2;
  localparam logic [3:0] C_TXE = 4'h3, C_TXW = 4'h4, C_TMR = 4'h5;
  localparam logic [3:0] C_NV = 4'h6, C_CMP = 4'h8;
  localparam logic [3:0] C_OSC = 4'hb, C_LV = 4'hc;
  logic       clock, rst_n, reg_wr, reg_rd, irq, evt_go;
  pif_addr_t  reg_addr;
  pif_byte_t  reg_wdata, reg_rdata;
  logic [3:0] evt_code;
  logic [7:0] pulse, level;
  int         bad_count, num_checks;

  pif_top pif_top_i (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .conv_done(pulse[0]),
    .rx_data_arrived(pulse[1]), .rx_buffer_read(pulse[2]),
    .tx_buffer_emptied(pulse[3]), .tx_buffer_written(pulse[4]),
    .comparator_out(level[2:0]), .timer_overflow(pulse[5]),
    .osc_failed(level[3]), .nv_write_done(pulse[6]),
    .low_voltage(level[4]));
  pif_periph_model pif_periph_model_i (.clock(clock), .rst_n(rst_n),
    .evt_code(evt_code), .evt_go(evt_go), .pulse(pulse), .level(level));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input pif_byte_t got, input pif_byte_t exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input pif_addr_t a, input pif_byte_t d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input pif_addr_t a, input pif_byte_t exp);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic ev(input logic [3:0] c);
    @(posedge clock);
    evt_code <= c;
    evt_go <= 1'b1;
    @(posedge clock);
    evt_go <= 1'b0;
  endtask
  task automatic irq_is(input logic e);
    @(posedge clock);
    #1 chk({7'h00, irq}, {7'h00, e});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4000) @(posedge clock);
    bad_count++;
    final_report();
  end
  initial begin
    rst_n = 1'b0;
    {reg_wr, reg_rd, evt_go, evt_code, reg_addr, reg_wdata} = '0;
    bad_count = 0;
    num_checks = 0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    for (int a = 0; a < 8; a++) rd(pif_addr_t'(a), 8'h00);
    wr(3'h6, 8'hff);
    rd(3'h6, 8'h00);
    ev(C_CONV);
    rd(OFF_FLAGS_ONE, 8'h40);
    rd(OFF_FLAGS_ONE, 8'h40);
    wr(OFF_FLAGS_ONE, 8'hff);
    rd(OFF_FLAGS_ONE, 8'h4f);
    // the read cleared the comparator flags; the timer flag was written one
    rd(OFF_FLAGS_ONE, 8'h41);
    wr(OFF_FLAGS_ONE, 8'h00);
    rd(OFF_FLAGS_ONE, 8'h00);
    ev(C_RXA);
    rd(OFF_FLAGS_ONE, 8'h20);
    ev(C_RXR);
    rd(OFF_FLAGS_ONE, 8'h00);
    ev(C_TXE);
    rd(OFF_FLAGS_ONE, 8'h10);
    ev(C_TXW);
    rd(OFF_FLAGS_ONE, 8'h00);
    ev(C_TMR);
    rd(OFF_FLAGS_ONE, 8'h01);
    rd(OFF_FLAGS_ONE, 8'h01);
    wr(OFF_FLAGS_ONE, 8'h00);
    rd(OFF_FLAGS_ONE, 8'h00);
    for (int i = 0; i < 3; i++) begin
      ev(C_CMP + 4'(i));
      rd(OFF_FLAGS_ONE, pif_byte_t'(8'h02 << i));
      rd(OFF_FLAGS_ONE, 8'h00);
    end
    ev(C_OSC);
    rd(OFF_FLAGS_TWO, 8'h80);
    ev(C_OSC);
    rd(OFF_FLAGS_TWO, 8'h80);
    wr(OFF_FLAGS_TWO, 8'h00);
    ev(C_NV);
    rd(OFF_FLAGS_TWO, 8'h10);
    wr(OFF_FLAGS_TWO, 8'h00);
    ev(C_LV);
    rd(OFF_FLAGS_TWO, 8'h04);
    ev(C_LV);
    wr(OFF_FLAGS_TWO, 8'h00);
    rd(OFF_FLAGS_TWO, 8'h00);
    wr(OFF_FLAGS_TWO, 8'hff);
    rd(OFF_FLAGS_TWO, 8'h94);
    wr(OFF_FLAGS_TWO, 8'h00);
    // status caught every event; rx read and tx write are not events
    rd(OFF_ISTAT_TWO, 8'h94);
    wr(OFF_ISTAT_ONE, 8'h0f);
    rd(OFF_ISTAT_ONE, 8'h70);
    wr(OFF_ISTAT_ONE, 8'hff);
    wr(OFF_ISTAT_TWO, 8'hff);
    rd(OFF_ISTAT_TWO, 8'h00);
    wr(OFF_FLAGS_ONE, 8'h00);
    wr(OFF_IMASK_ONE, 8'h40);
    rd(OFF_IMASK_ONE, 8'h40);
    ev(C_TMR);
    irq_is(1'b0);
    ev(C_CONV);
    irq_is(1'b1);
    wr(OFF_ISTAT_ONE, 8'h40);
    irq_is(1'b0);
    wr(OFF_IMASK_ONE, 8'h41);
    irq_is(1'b1);
    wr(OFF_ISTAT_ONE, 8'hff);
    irq_is(1'b0);
    wr(OFF_IMASK_TWO, 8'h10);
    rd(OFF_IMASK_TWO, 8'h10);
    ev(C_NV);
    irq_is(1'b1);
    wr(OFF_ISTAT_TWO, 8'hff);
    irq_is(1'b0);
    final_report();
  end
endmodule // tb_peripheral_interrupt_flags

`default_nettype wire
